// >>> sel_pkg.sv
// Constants shared by the serial configuration memory loader.
package sel_pkg;
    // Clock and serial clock timing.
    localparam int CLK_NS      = 10;
    localparam int SK_HALF_NS  = 500;
    localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] SK_HALF_LAST = 8'(SK_HALF_CYC - 1);

    // Instruction field: a start bit of one, then a two-bit opcode.
    localparam logic [1:0] OP_EXT   = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [4:0] INSTR_BITS = 5'h03;
    localparam logic [4:0] ABITS_S    = 5'h06;
    localparam logic [4:0] ABITS_L    = 5'h08;
    localparam logic [4:0] DATA_BITS  = 5'h10;

    // Word addresses of the image.
    localparam logic [7:0] W_SA0   = 8'h00;
    localparam logic [7:0] W_SA1   = 8'h01;
    localparam logic [7:0] W_SA2   = 8'h02;
    localparam logic [7:0] W_IMG   = 8'h0A;
    localparam logic [7:0] W_SUB   = 8'h0B;
    localparam logic [7:0] W_SVID  = 8'h0C;
    localparam logic [7:0] W_PTR   = 8'h0D;
    localparam logic [7:0] W_DEVID = 8'h23;
    localparam logic [7:0] W_MDM0  = 8'hFB;
    localparam logic [7:0] W_MDM1  = 8'hFC;
    localparam logic [7:0] W_MDM2  = 8'hFD;
    localparam logic [7:0] W_MDM3  = 8'hFE;

    // Load list: five base words, eleven with the modem words.
    localparam logic [3:0] LD_BASE = 4'h5;
    localparam logic [3:0] LD_ALL  = 4'hB;
    localparam logic [3:0] LD_IMG  = 4'h3;
    localparam int MODEM_BIT     = 0;
    localparam int EXPROM_DIS_BIT = 1;

    // Transaction sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_SHIFT = 3'h1,
        ST_READ  = 3'h2,
        ST_DESEL = 3'h3,
        ST_BUSY  = 3'h4,
        ST_DONE  = 3'h5
    } sel_state_type;

    // Owner of the current transaction.
    typedef enum logic [1:0] {
        OWN_LOAD = 2'h0,
        OWN_HB   = 2'h1,
        OWN_HOST = 2'h2
    } sel_owner_type;
endpackage

// >>> sel_loader.sv
// Serial configuration memory controller with automatic load after reset.
module sel_loader
    import sel_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // Serial memory pins.
    output logic             ee_cs_o,
    output logic             ee_sk_o,
    output logic             ee_di_o,
    input  wire logic        ee_do_i,
    // Host access port.
    input  wire logic        host_req_i,
    input  wire logic [1:0]  host_op_i,
    input  wire logic [7:0]  host_addr_i,
    input  wire logic [15:0] host_wdata_i,
    output logic             host_ready_o,
    output logic             host_done_o,
    output logic [15:0]      host_rdata_o,
    // Heartbeat fetch port.
    input  wire logic        hb_req_i,
    input  wire logic [7:0]  hb_addr_i,
    output logic             hb_valid_o,
    output logic [15:0]      hb_data_o,
    // Bus retry arbitration.
    input  wire logic        pci_ee_acc_i,
    input  wire logic        pci_flash_acc_i,
    output logic             window_o,
    output logic             retry_o,
    // Loaded configuration.
    output logic             loaded_o,
    output logic             large_part_o,
    output logic [47:0]      station_address_o,
    output logic [15:0]      image_identity_word_o,
    output logic [15:0]      subsys_ident_o,
    output logic [15:0]      subsys_vendor_o,
    output logic [7:0]       cfg_hb_ptr_o,
    output logic [7:0]       smb_cis_ptr_o,
    output logic             modem_present_o,
    output logic             exprom_disable_o,
    output logic [63:0]      modem_words_o,
    output logic [15:0]      device_id_o
);
    import sel_pkg::*;

    sel_state_type state, next_state;
    sel_owner_type owner, next_owner;
    logic [7:0]  div, next_div;
    logic        sk, next_sk, cs, next_cs, di, next_di;
    logic [26:0] sr, next_sr;
    logic [15:0] rd, next_rd;
    logic [4:0]  cnt, next_cnt;
    logic [1:0]  op, next_op;
    logic [7:0]  addr, next_addr;
    logic        sized, next_sized, alen8, next_alen8;
    logic        loaded, next_loaded;
    logic [3:0]  ld_idx, next_ld_idx;
    logic [15:0] words [0:10];
    logic [15:0] next_words [0:10];
    logic        host_ready, next_host_ready;
    logic        host_done, next_host_done;
    logic [15:0] host_rdata, next_host_rdata;
    logic        hb_valid, next_hb_valid;
    logic [15:0] hb_data, next_hb_data;
    logic        window, next_window, retry, next_retry;
    logic [15:0] dev_id, next_dev_id;
    logic        s1, s2, s3, do_f, next_do_f;
    logic        tick, bd;
    logic [4:0]  nb;

    // Word address for each entry of the load list.
    function automatic logic [7:0] ld_addr(input logic [3:0] idx);
        case (idx)
            4'h0:    ld_addr = W_SA0;
            4'h1:    ld_addr = W_SA1;
            4'h2:    ld_addr = W_SA2;
            4'h3:    ld_addr = W_IMG;
            4'h4:    ld_addr = W_PTR;
            4'h5:    ld_addr = W_SUB;
            4'h6:    ld_addr = W_SVID;
            4'h7:    ld_addr = W_MDM0;
            4'h8:    ld_addr = W_MDM1;
            4'h9:    ld_addr = W_MDM2;
            default: ld_addr = W_MDM3;
        endcase
    endfunction

    // Build the outgoing bit stream, instruction first, MSB leading.
    function automatic logic [26:0] mk_sr(input logic [1:0] o,
                                          input logic [7:0] a,
                                          input logic [15:0] d,
                                          input logic l8);
        if (l8) begin
            mk_sr = {1'b1, o, a, d};
        end else begin
            mk_sr = {1'b1, o, a[5:0], d, 2'h0};
        end
    endfunction

    assign tick = (div == SK_HALF_LAST);
    assign bd   = tick & sk;
    assign nb   = cnt + 5'h01;

    // Sequencer, bit engine and result delivery.
    always_comb begin
        next_state = state;
        next_owner = owner;
        next_div = tick ? 8'h00 : div + 8'h01;
        next_sk = sk;
        next_cs = cs;
        next_sr = sr;
        next_rd = rd;
        next_cnt = cnt;
        next_op = op;
        next_addr = addr;
        next_sized = sized;
        next_alen8 = alen8;
        next_loaded = loaded;
        next_ld_idx = ld_idx;
        next_words = words;
        next_host_done = 1'b0;
        next_host_rdata = host_rdata;
        next_hb_valid = 1'b0;
        next_hb_data = hb_data;
        next_dev_id = dev_id;
        next_do_f = (s2 == s3) ? s3 : do_f;
        case (state)
            ST_IDLE: begin
                next_sk = 1'b0;
                next_cs = 1'b0;
                next_div = 8'h00;
                next_cnt = 5'h00;
                // The load wins over everything, then heartbeat, then host.
                // A heartbeat request still held in its result cycle is
                // not taken a second time.
                if (!loaded) begin
                    next_owner = OWN_LOAD;
                    next_op = OP_READ;
                    next_addr = ld_addr(ld_idx);
                end else if (hb_req_i && !hb_valid) begin
                    next_owner = OWN_HB;
                    next_op = OP_READ;
                    next_addr = hb_addr_i;
                end else if (host_req_i && host_ready) begin
                    next_owner = OWN_HOST;
                    next_op = host_op_i;
                    next_addr = host_addr_i;
                end
                if (!loaded || (hb_req_i && !hb_valid)
                    || (host_req_i && host_ready)) begin
                    next_state = ST_SHIFT;
                    next_cs = 1'b1;
                    next_sr = mk_sr(next_op, next_addr, host_wdata_i, alen8);
                end
            end
            ST_SHIFT: begin
                if (tick) begin
                    next_sk = ~sk;
                end
                if (bd) begin
                    next_sr = {sr[25:0], 1'b0};
                    next_cnt = nb;
                    if (op == OP_READ) begin
                        // Unsized: a zero after the six address bits means the small part.
                        if (!sized && nb == INSTR_BITS + ABITS_S
                            && !do_f) begin
                            next_alen8 = 1'b0;
                            next_sized = 1'b1;
                            next_state = ST_READ;
                            next_cnt = 5'h00;
                        end else if (nb == INSTR_BITS
                                     + (alen8 ? ABITS_L : ABITS_S)) begin
                            next_sized = 1'b1;
                            next_state = ST_READ;
                            next_cnt = 5'h00;
                        end
                    end else if (nb == INSTR_BITS
                                 + (alen8 ? ABITS_L : ABITS_S)
                                 + (op == OP_WRITE ? DATA_BITS : 5'h00)) begin
                        next_state = ST_DESEL;
                        next_cs = 1'b0;
                    end
                end
            end
            ST_READ: begin
                if (tick) begin
                    next_sk = ~sk;
                end
                if (bd) begin
                    next_rd = {rd[14:0], do_f};
                    next_cnt = nb;
                    if (nb == DATA_BITS) begin
                        next_state = ST_DESEL;
                        next_cs = 1'b0;
                    end
                end
            end
            ST_DESEL: begin
                next_sk = 1'b0;
                next_cs = 1'b0;
                if (tick) begin
                    // Programming ops poll the ready level before releasing.
                    if (op == OP_WRITE || op == OP_ERASE) begin
                        next_state = ST_BUSY;
                        next_cs = 1'b1;
                    end else begin
                        next_state = ST_DONE;
                    end
                end
            end
            ST_BUSY: begin
                // Reuse the deselect wait so the next select keeps its gap.
                if (tick && do_f) begin
                    next_cs = 1'b0;
                    next_op = OP_EXT;
                    next_state = ST_DESEL;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
                case (owner)
                    OWN_LOAD: begin
                        next_words[ld_idx] = rd;
                        next_ld_idx = ld_idx + 4'h1;
                        if ((ld_idx == LD_BASE - 4'h1
                             && !words[LD_IMG][MODEM_BIT])
                            || ld_idx == LD_ALL - 4'h1) begin
                            next_loaded = 1'b1;
                        end
                    end
                    OWN_HB: begin
                        next_hb_data = rd;
                        next_hb_valid = 1'b1;
                    end
                    default: begin
                        next_host_rdata = rd;
                        next_host_done = 1'b1;
                        if (op == OP_READ && addr == W_DEVID) begin
                            next_dev_id = rd;
                        end
                    end
                endcase
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        next_di = (next_state == ST_SHIFT) ? next_sr[26] : 1'b0;
        next_window = (next_state != ST_IDLE) && (next_owner == OWN_HB);
        next_retry = next_window
                     & (pci_ee_acc_i | pci_flash_acc_i);
        next_host_ready = next_loaded && (next_state == ST_IDLE)
                          && (state == ST_IDLE)
                          && !(host_req_i && host_ready);
    end

    // State registers; the first synchroniser stage feeds only the second.
    always_ff @(posedge clk_i) begin
        s1 <= ee_do_i;
        s2 <= s1;
        s3 <= s2;
        if (srst_i) begin
            state <= ST_IDLE;
            owner <= OWN_LOAD;
            div <= 8'h00;
            sk <= 1'b0;
            cs <= 1'b0;
            di <= 1'b0;
            sr <= 27'h0000000;
            rd <= 16'h0000;
            cnt <= 5'h00;
            op <= OP_READ;
            addr <= 8'h00;
            sized <= 1'b0;
            alen8 <= 1'b1;
            loaded <= 1'b0;
            ld_idx <= 4'h0;
            for (int i = 0; i < 11; i++) begin
                words[i] <= 16'h0000;
            end
            host_ready <= 1'b0;
            host_done <= 1'b0;
            host_rdata <= 16'h0000;
            hb_valid <= 1'b0;
            hb_data <= 16'h0000;
            window <= 1'b0;
            retry <= 1'b0;
            dev_id <= 16'h0000;
            do_f <= 1'b1;
        end else begin
            state <= next_state;
            owner <= next_owner;
            div <= next_div;
            sk <= next_sk;
            cs <= next_cs;
            di <= next_di;
            sr <= next_sr;
            rd <= next_rd;
            cnt <= next_cnt;
            op <= next_op;
            addr <= next_addr;
            sized <= next_sized;
            alen8 <= next_alen8;
            loaded <= next_loaded;
            ld_idx <= next_ld_idx;
            words <= next_words;
            host_ready <= next_host_ready;
            host_done <= next_host_done;
            host_rdata <= next_host_rdata;
            hb_valid <= next_hb_valid;
            hb_data <= next_hb_data;
            window <= next_window;
            retry <= next_retry;
            dev_id <= next_dev_id;
            do_f <= next_do_f;
        end
    end

    // Pins and status straight from registers.
    assign ee_cs_o = cs;
    assign ee_sk_o = sk;
    assign ee_di_o = di;
    assign host_ready_o = host_ready;
    assign host_done_o = host_done;
    assign host_rdata_o = host_rdata;
    assign hb_valid_o = hb_valid;
    assign hb_data_o = hb_data;
    assign window_o = window;
    assign retry_o = retry;
    assign loaded_o = loaded;
    assign large_part_o = alen8;
    assign device_id_o = dev_id;

    // Decoded configuration fields of the loaded words.
    assign station_address_o = {words[2], words[1], words[0]};
    assign image_identity_word_o = words[3];
    assign modem_present_o = words[3][MODEM_BIT];
    assign exprom_disable_o = words[3][EXPROM_DIS_BIT];
    assign cfg_hb_ptr_o = words[4][15:8];
    assign smb_cis_ptr_o = words[4][7:0];
    assign subsys_ident_o = words[5];
    assign subsys_vendor_o = words[6];
    assign modem_words_o = {words[10], words[9], words[8], words[7]};
endmodule

// >>> sel_loader_sva.sv
// Assertions on the loader's memory pins, handshakes and retry output.
module sel_loader_chk
    import sel_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic srst_i,
    // Memory pins.
    input wire logic ee_cs_o,
    input wire logic ee_sk_o,
    input wire logic ee_di_o,
    // Handshakes and status.
    input wire logic host_ready_o,
    input wire logic host_done_o,
    input wire logic hb_valid_o,
    input wire logic pci_ee_acc_i,
    input wire logic pci_flash_acc_i,
    input wire logic window_o,
    input wire logic retry_o,
    input wire logic loaded_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] hi_cnt;
    logic [7:0] lo_cnt;
    logic [5:0] rise_cnt;
    logic [1:0] op_bits;
    logic       poll_due;
    logic       sk_q;
    logic       cs_q;

    // Write and erase end in a ready poll that raises select with no start.
    always_ff @(posedge clk_i) begin
        sk_q <= ee_sk_o;
        cs_q <= ee_cs_o;
        if (srst_i) begin
            rise_cnt <= 6'h00;
            op_bits <= 2'h0;
            poll_due <= 1'b0;
        end else begin
            if (cs_q && !ee_cs_o) begin
                poll_due <= (rise_cnt >= 6'h03) && op_bits[0];
            end
            if (!ee_cs_o) begin
                rise_cnt <= 6'h00;
            end else if (ee_sk_o && !sk_q) begin
                rise_cnt <= rise_cnt + 6'h01;
                if (rise_cnt < 6'h03) begin
                    op_bits <= {op_bits[0], ee_di_o};
                end
            end
        end
    end

    // Idle time saturates and starts full, so reset release is no short gap.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hi_cnt <= 8'h00;
            lo_cnt <= 8'hFF;
        end else begin
            hi_cnt <= ee_sk_o ? hi_cnt + 8'h01 : 8'h00;
            lo_cnt <= ee_cs_o ? 8'h00 : lo_cnt + 8'(lo_cnt != 8'hFF);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    chk_sk_high_time: assert property (
        $fell(ee_sk_o) |-> hi_cnt == 8'(SK_HALF_CYC))
        else $error("serial clock high time wrong");
    chk_cs_idle_gap: assert property (
        $rose(ee_cs_o) |-> lo_cnt >= 8'h32)
        else $error("chip select gap too short");
    chk_start_bit: assert property (
        $rose(ee_cs_o) && !poll_due |-> ee_di_o && !ee_sk_o)
        else $error("transaction lacks start bit");
    chk_poll_quiet: assert property (
        $rose(ee_cs_o) && poll_due |-> !ee_di_o && !ee_sk_o)
        else $error("ready poll drives clock or data");
    chk_di_on_fall: assert property (
        ee_cs_o && $past(ee_cs_o) && $changed(ee_di_o) |-> $fell(ee_sk_o))
        else $error("data out moved off clock fall");
    chk_sk_idle: assert property (
        !ee_cs_o |-> !ee_sk_o)
        else $error("serial clock runs while deselected");
    chk_retry_cause: assert property (
        retry_o == (window_o && $past(pci_ee_acc_i || pci_flash_acc_i)))
        else $error("retry does not follow window and access");
    chk_ready_loaded: assert property (
        host_ready_o |-> loaded_o && !window_o && !ee_cs_o)
        else $error("host ready while busy or unloaded");
    chk_done_pulse: assert property (
        host_done_o |=> !host_done_o && host_ready_o)
        else $error("host done not a pulse followed by ready");
    chk_hb_valid: assert property (
        hb_valid_o |-> $past(window_o) && !window_o ##1 !hb_valid_o)
        else $error("heartbeat result outside its window");
endmodule

bind sel_loader sel_loader_chk u_chk (
    .clk_i(clk_i), .srst_i(srst_i), .ee_cs_o(ee_cs_o),
    .ee_sk_o(ee_sk_o), .ee_di_o(ee_di_o), .host_ready_o(host_ready_o),
    .host_done_o(host_done_o), .hb_valid_o(hb_valid_o),
    .pci_ee_acc_i(pci_ee_acc_i), .pci_flash_acc_i(pci_flash_acc_i),
    .window_o(window_o), .retry_o(retry_o), .loaded_o(loaded_o)
);

// >>> sel_mem_model.sv
// Behavioural serial configuration memory on the loader's pins.
module sel_mem_model
    import sel_pkg::*;
#(
    parameter int WORDS = 256
) (
    // Memory side pins.
    input  wire logic cs_i,
    input  wire logic sk_i,
    input  wire logic di_i,
    output logic      do_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AB = (WORDS == 256) ? 8 : 6;
    logic [15:0] mem [WORDS];
    logic [15:0] sh;
    logic [15:0] sum;
    logic [7:0]  adr;
    logic [1:0]  op;
    logic        drv;
    int          n;

    // Address pattern image with a flags word at Ah and the checksum last.
    initial begin
        sum = 16'h0000;
        for (int i = 0; i < WORDS - 1; i++) begin
            mem[i] = {8'(i) ^ 8'h3C, 8'(i)};
            if (i == 10) mem[i] = (WORDS == 256) ? 16'hC303 : 16'hC300;
            sum += mem[i];
        end
        mem[WORDS - 1] = 16'hBABA - sum;
        do_o = 1'b1;
        drv = 1'b0;
        n = 0;
    end

    // Bits enter on clock rise; output is pulled up when not answering.
    always @(posedge sk_i or negedge cs_i) begin
        if (!cs_i) begin
            n = 0;
            drv = 1'b0;
            do_o = 1'b1;
        end else begin
            n = n + 1;
            if (n == 1) adr = 8'h00;
            if (n == 2 || n == 3) op = {op[0], di_i};
            if (n > 3 && n <= 3 + AB) adr = {adr[6:0], di_i};
            if (drv) begin
                do_o = sh[15];
                sh = {sh[14:0], 1'b1};
            end
            if (n == 3 + AB && op == OP_READ) begin
                sh = mem[adr];
                drv = 1'b1;
                do_o = 1'b0;
            end
            if (op == OP_WRITE && n > 3 + AB) sh = {sh[14:0], di_i};
            if (op == OP_WRITE && n == 3 + AB + 16) mem[adr] = sh;
        end
    end
endmodule

// >>> testbench.sv
// Bench: automatic load, host access, heartbeat window and retry.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sel_pkg::*;

    logic        clk_i;
    logic        srst_i;
    logic        req [2];
    logic [1:0]  h_op;
    logic [7:0]  h_addr;
    logic [7:0]  hb_addr;
    logic [15:0] h_wdata;
    logic        hb_req;
    logic        ee_acc;
    logic        fl_acc;
    wire         cs [2], sk [2], di [2], dout [2], rdy [2], done [2];
    wire         hbv [2], win [2], rty [2], ld [2], lg [2], mdm [2], exr [2];
    wire [15:0]  rd [2], hbd [2], iw [2], sub [2], ven [2], dev [2];
    wire [7:0]   cp [2], sp [2];
    wire [47:0]  sta [2];
    wire [63:0]  mw [2];
    int          mismatches;
    int          comparisons;

    // Index 0 faces a 256-word part, index 1 a 64-word part.
    for (genvar g = 0; g < 2; g++) begin : g_pair
        sel_loader u_dut (
            .clk_i(clk_i), .srst_i(srst_i), .ee_cs_o(cs[g]),
            .ee_sk_o(sk[g]), .ee_di_o(di[g]), .ee_do_i(dout[g]),
            .host_req_i(req[g]), .host_op_i(h_op), .host_addr_i(h_addr),
            .host_wdata_i(h_wdata), .host_ready_o(rdy[g]),
            .host_done_o(done[g]), .host_rdata_o(rd[g]),
            .hb_req_i(hb_req && g == 0), .hb_addr_i(hb_addr),
            .hb_valid_o(hbv[g]), .hb_data_o(hbd[g]),
            .pci_ee_acc_i(ee_acc && g == 0),
            .pci_flash_acc_i(fl_acc && g == 0), .window_o(win[g]),
            .retry_o(rty[g]), .loaded_o(ld[g]), .large_part_o(lg[g]),
            .station_address_o(sta[g]), .image_identity_word_o(iw[g]),
            .subsys_ident_o(sub[g]), .subsys_vendor_o(ven[g]),
            .cfg_hb_ptr_o(cp[g]), .smb_cis_ptr_o(sp[g]),
            .modem_present_o(mdm[g]), .exprom_disable_o(exr[g]),
            .modem_words_o(mw[g]), .device_id_o(dev[g]));
        // The heartbeat feature needs the large part, so only index 0 gets it.
        sel_mem_model #(.WORDS(g == 0 ? 256 : 64)) u_mem (
            .cs_i(cs[g]), .sk_i(sk[g]), .di_i(di[g]), .do_o(dout[g]));
    end

    function automatic logic [15:0] img(input logic [7:0] a,
                                        input logic big);
        if (a == 8'h0A) return big ? 16'hC303 : 16'hC300;
        return {a ^ 8'h3C, a};
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s: %h vs %h", $time, what, got, exp);
        end
    endtask

    // Request held until done; dropped at the edge after the pulse.
    task automatic host_xfer(input int g, input logic [1:0] op,
                             input logic [7:0] a, input logic [15:0] wd);
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (rdy[g] !== 1'b1 && n < 9000);
        @(posedge clk_i);
        h_op <= op;
        h_addr <= a;
        h_wdata <= wd;
        req[g] <= 1'b1;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (done[g] !== 1'b1 && n < 9000);
        chk(done[g], 1'b1, "host done");
        @(posedge clk_i);
        req[g] <= 1'b0;
    endtask

    task automatic t_autoload();
        int n;
        logic b;
        n = 0;
        while ((ld[0] !== 1'b1 || ld[1] !== 1'b1) && n < 60000) begin
            @(negedge clk_i);
            n++;
        end
        for (int g = 0; g < 2; g++) begin
            b = (g == 0);
            chk(ld[g], 1'b1, "load finished");
            chk(lg[g], b, "part size");
            chk(sta[g], {img(2, b), img(1, b), img(0, b)}, "station");
            chk(iw[g], img(8'h0A, b), "image word");
            chk({cp[g], sp[g]}, img(8'h0D, b), "pointers");
            chk({mdm[g], exr[g]}, {b, b}, "flags");
            chk(sub[g], b ? img(8'h0B, b) : 16'h0000, "subsys");
            chk(ven[g], b ? img(8'h0C, b) : 16'h0000, "vendor");
            chk(mw[g], b ? {img(8'hFE, b), img(8'hFD, b), img(8'hFC, b),
                            img(8'hFB, b)} : 64'h0, "modem words");
        end
    endtask

    task automatic t_host();
        for (int g = 0; g < 2; g++) begin
            host_xfer(g, OP_READ, 8'h23, 16'h0000);
            chk(rd[g], img(8'h23, 1'b0), "read 23h");
            chk(dev[g], img(8'h23, 1'b0), "device id");
            host_xfer(g, OP_EXT, 8'hFF, 16'h0000);
            host_xfer(g, OP_WRITE, 8'h3F, 16'hBE01 + 16'(g));
            host_xfer(g, OP_READ, 8'h3F, 16'h0000);
            chk(rd[g], 16'hBE01 + 16'(g), "write back");
        end
    endtask

    task automatic t_heartbeat();
        int n;
        @(posedge clk_i);
        hb_addr <= 8'hFC;
        hb_req <= 1'b1;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (win[0] !== 1'b1 && n < 200);
        chk(win[0], 1'b1, "window open");
        chk(rdy[0], 1'b0, "ready in window");
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i);
            {fl_acc, ee_acc} <= (i == 1) ? 2'b10 : 2'b01;
            @(posedge clk_i);
            @(negedge clk_i);
            chk(rty[0], 1'b1, "retry in window");
        end
        @(posedge clk_i);
        {fl_acc, ee_acc} <= 2'b00;
        do begin
            @(negedge clk_i);
            n++;
        end while (hbv[0] !== 1'b1 && n < 9000);
        chk(hbd[0], img(8'hFC, 1'b1), "heartbeat word");
        @(posedge clk_i);
        hb_req <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (win[0] !== 1'b0 && n < 9000);
        chk(win[0], 1'b0, "window closed");
        @(posedge clk_i);
        ee_acc <= 1'b1;
        repeat (2) @(negedge clk_i);
        chk(rty[0], 1'b0, "retry outside window");
        @(posedge clk_i);
        ee_acc <= 1'b0;
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Free running 100 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // The whole run needs about half this span; a hang ends in the verdict.
    initial begin
        #1000000;
        mismatches++;
        print_verdict();
    end

    // Reset for three cycles, then the scenarios in turn.
    initial begin
        srst_i = 1'b1;
        req[0] = 1'b0;
        req[1] = 1'b0;
        h_op = OP_READ;
        h_addr = 8'h00;
        h_wdata = 16'h0000;
        hb_req = 1'b0;
        hb_addr = 8'h00;
        ee_acc = 1'b0;
        fl_acc = 1'b0;
        mismatches = 0;
        comparisons = 0;
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        t_autoload();
        t_host();
        t_heartbeat();
        print_verdict();
    end
endmodule
